// File: pfbm_pkg.sv
package pfbm_pkg;

  // ----------------------------------------------------------------
  // Address spaces
  // ----------------------------------------------------------------
  localparam int          PFBM_CODE_AW   = 16;
  localparam int          PFBM_LIN_AW    = 17;
  localparam int          PFBM_WIN_BIT   = 15;
  localparam int          PFBM_DATA_AW   = 8;
  localparam int          PFBM_DATA_BYTES = 256;
  localparam logic [16:0] PFBM_RSVD_BASE = 17'h1fc00;

  // ----------------------------------------------------------------
  // Bank select register
  // ----------------------------------------------------------------
  localparam logic [7:0]  PFBM_BANK_SEL_ADDR = 8'hb1;
  localparam logic [7:0]  PFBM_BANK_SEL_RST  = 8'h11;
  localparam logic [7:0]  PFBM_BANK_SEL_MASK = 8'h33;
  localparam int          PFBM_FETCH_LSB     = 0;
  localparam int          PFBM_CONST_LSB     = 4;
  localparam logic [1:0]  PFBM_BANK0         = 2'h0;

  // ----------------------------------------------------------------
  // Access kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PFBM_ACC_NONE  = 2'b00,
    PFBM_ACC_FETCH = 2'b01,
    PFBM_ACC_CONST = 2'b10,
    PFBM_ACC_XMOVE = 2'b11
  } pfbm_acc_type;

  function automatic logic [1:0] pfbm_field(input logic [7:0] sel, input int lsb);
    pfbm_field = sel[lsb +: 2];
  endfunction

endpackage

// File: pfbm_bank_decode.sv
`timescale 1ns/1ns
module pfbm_bank_decode
#(
  parameter bit BANKED = 1'b1
)
(
  // Core address and selected bank field
  input  wire logic [pfbm_pkg::PFBM_CODE_AW-1:0] addr_i,
  input  wire logic [1:0]                        field_i,
  // Linear flash address
  output logic      [pfbm_pkg::PFBM_LIN_AW-1:0]  lin_addr_o,
  output logic      [1:0]                        bank_o,
  output logic                                   reserved_o
);
  import pfbm_pkg::*;

  always_comb
  begin
    if (!BANKED)
    begin
      // One flat region, no window
      bank_o     = PFBM_BANK0;
      lin_addr_o = {1'b0, addr_i};
    end
    else if (!addr_i[PFBM_WIN_BIT])
    begin
      bank_o     = PFBM_BANK0;
      lin_addr_o = {PFBM_BANK0, addr_i[PFBM_WIN_BIT-1:0]};
    end
    else
    begin
      // Field value is the bank number, 00 giving bank 0 again
      bank_o     = field_i;
      lin_addr_o = {field_i, addr_i[PFBM_WIN_BIT-1:0]};
    end
    reserved_o = BANKED && (lin_addr_o >= PFBM_RSVD_BASE);
  end

endmodule

// File: pfbm_mapper.sv
`timescale 1ns/1ns
module pfbm_mapper
#(
  parameter bit BANKED = 1'b1
)
(
  // Clock and reset
  input  wire logic                                 clk_sys_i,
  input  wire logic                                 sys_rst_i,
  // Instruction fetch
  input  wire logic                                 fetch_req_i,
  input  wire logic [pfbm_pkg::PFBM_CODE_AW-1:0]    fetch_addr_i,
  // Code byte read
  input  wire logic                                 const_rd_i,
  input  wire logic [pfbm_pkg::PFBM_CODE_AW-1:0]    const_addr_i,
  // External move
  input  wire logic                                 xmove_rd_i,
  input  wire logic                                 xmove_wr_i,
  input  wire logic [pfbm_pkg::PFBM_CODE_AW-1:0]    xmove_addr_i,
  input  wire logic [7:0]                           xmove_wdata_i,
  input  wire logic                                 program_store_wr_en_i,
  // Special function register port
  input  wire logic                                 sfr_rd_i,
  input  wire logic                                 sfr_wr_i,
  input  wire logic [7:0]                           sfr_addr_i,
  input  wire logic [7:0]                           sfr_wdata_i,
  output logic      [7:0]                           sfr_rdata_o,
  // Internal data memory
  input  wire logic                                 data_rd_i,
  input  wire logic                                 data_wr_i,
  input  wire logic [pfbm_pkg::PFBM_DATA_AW-1:0]    data_addr_i,
  input  wire logic [7:0]                           data_wdata_i,
  output logic      [7:0]                           data_rdata_o,
  // Flash array
  output logic                                      flash_rd_o,
  output logic                                      flash_fetch_o,
  output logic                                      flash_wr_o,
  output logic      [pfbm_pkg::PFBM_LIN_AW-1:0]     flash_addr_o,
  output logic      [7:0]                           flash_wdata_o,
  output logic      [1:0]                           flash_bank_o,
  output logic                                      reserved_hit_o,
  // External data space
  output logic                                      xdata_rd_o,
  output logic                                      xdata_wr_o,
  output logic      [pfbm_pkg::PFBM_CODE_AW-1:0]    xdata_addr_o,
  output logic      [7:0]                           xdata_wdata_o
);
  import pfbm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]              program_bank_select;
  logic [7:0]              next_program_bank_select;
  logic [1:0]              exec_bank;
  logic [1:0]              next_exec_bank;
  logic [7:0]              data_mem [PFBM_DATA_BYTES];
  logic [7:0]              next_data_mem [PFBM_DATA_BYTES];

  logic [7:0]              next_sfr_rdata;
  logic [7:0]              next_data_rdata;
  logic                    next_flash_rd;
  logic                    next_flash_fetch;
  logic                    next_flash_wr;
  logic [PFBM_LIN_AW-1:0]  next_flash_addr;
  logic [7:0]              next_flash_wdata;
  logic [1:0]              next_flash_bank;
  logic                    next_reserved_hit;
  logic                    next_xdata_rd;
  logic                    next_xdata_wr;
  logic [PFBM_CODE_AW-1:0] next_xdata_addr;
  logic [7:0]              next_xdata_wdata;

  // ----------------------------------------------------------------
  // Access selection and decode
  // ----------------------------------------------------------------
  pfbm_acc_type            acc_kind;
  logic [PFBM_CODE_AW-1:0] dec_addr;
  logic [1:0]              dec_field;
  logic [PFBM_LIN_AW-1:0]  dec_lin;
  logic [1:0]              dec_bank;
  logic                    dec_rsvd;
  logic                    to_flash;
  logic                    sel_hit;

  // Core issues one program access per cycle; fetch wins if it overlaps
  always_comb
  begin
    if (fetch_req_i)
      acc_kind = PFBM_ACC_FETCH;
    else if (const_rd_i)
      acc_kind = PFBM_ACC_CONST;
    else if (xmove_rd_i || xmove_wr_i)
      acc_kind = PFBM_ACC_XMOVE;
    else
      acc_kind = PFBM_ACC_NONE;
  end

  always_comb
  begin
    unique case (acc_kind)
      PFBM_ACC_FETCH:
      begin
        dec_addr  = fetch_addr_i;
        dec_field = pfbm_field(program_bank_select, PFBM_FETCH_LSB);
      end
      PFBM_ACC_CONST:
      begin
        dec_addr  = const_addr_i;
        dec_field = pfbm_field(program_bank_select, PFBM_CONST_LSB);
      end
      PFBM_ACC_XMOVE:
      begin
        dec_addr  = xmove_addr_i;
        dec_field = pfbm_field(program_bank_select, PFBM_CONST_LSB);
      end
      PFBM_ACC_NONE:
      begin
        dec_addr  = '0;
        dec_field = PFBM_BANK0;
      end
    endcase
  end

  pfbm_bank_decode
  #(
    .BANKED     (BANKED)
  )
  u_decode
  (
    .addr_i     (dec_addr),
    .field_i    (dec_field),
    .lin_addr_o (dec_lin),
    .bank_o     (dec_bank),
    .reserved_o (dec_rsvd)
  );

  // Writes reach flash only while the store enable is set
  assign to_flash = (acc_kind == PFBM_ACC_FETCH) || (acc_kind == PFBM_ACC_CONST) ||
                    ((acc_kind == PFBM_ACC_XMOVE) && xmove_wr_i && program_store_wr_en_i);
  assign sel_hit  = (sfr_addr_i == PFBM_BANK_SEL_ADDR);

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_program_bank_select = program_bank_select;
    next_exec_bank           = exec_bank;
    next_data_mem            = data_mem;
    next_sfr_rdata           = 8'h00;
    next_data_rdata          = data_rdata_o;
    next_flash_rd            = 1'b0;
    next_flash_fetch         = 1'b0;
    next_flash_wr            = 1'b0;
    next_flash_addr          = flash_addr_o;
    next_flash_wdata         = flash_wdata_o;
    next_flash_bank          = flash_bank_o;
    next_reserved_hit        = 1'b0;
    next_xdata_rd            = 1'b0;
    next_xdata_wr            = 1'b0;
    next_xdata_addr          = xdata_addr_o;
    next_xdata_wdata         = xdata_wdata_o;

    // Bank select write; reserved bits always hold zero
    if (sfr_wr_i && sel_hit)
    begin
      next_program_bank_select[PFBM_CONST_LSB +: 2] = sfr_wdata_i[PFBM_CONST_LSB +: 2];
      // Running code from an upper bank must not pull its own window away
      if (exec_bank == PFBM_BANK0)
        next_program_bank_select[PFBM_FETCH_LSB +: 2] = sfr_wdata_i[PFBM_FETCH_LSB +: 2];
    end
    if (sfr_rd_i && sel_hit)
      next_sfr_rdata = program_bank_select & PFBM_BANK_SEL_MASK;

    // Bank of the code now executing follows the last fetch
    if (acc_kind == PFBM_ACC_FETCH)
      next_exec_bank = dec_bank;

    if (to_flash)
    begin
      next_flash_addr  = dec_lin;
      next_flash_bank  = dec_bank;
      next_flash_wdata = xmove_wdata_i;
      if (dec_rsvd)
        next_reserved_hit = 1'b1;
      else if (acc_kind == PFBM_ACC_XMOVE)
        next_flash_wr = 1'b1;
      else
      begin
        next_flash_rd    = 1'b1;
        next_flash_fetch = (acc_kind == PFBM_ACC_FETCH);
      end
    end
    else if (acc_kind == PFBM_ACC_XMOVE)
    begin
      // Program memory stays read-only; the move lands in data space
      next_xdata_addr  = xmove_addr_i;
      next_xdata_wdata = xmove_wdata_i;
      next_xdata_wr    = xmove_wr_i;
      next_xdata_rd    = !xmove_wr_i;
    end

    // Internal data memory, a space apart from program memory
    if (data_wr_i)
      next_data_mem[data_addr_i] = data_wdata_i;
    if (data_rd_i)
      next_data_rdata = data_mem[data_addr_i];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      program_bank_select <= PFBM_BANK_SEL_RST;
      exec_bank           <= PFBM_BANK0;
      for (int i = 0; i < PFBM_DATA_BYTES; i++)
        data_mem[i] <= 8'h00;
      sfr_rdata_o         <= 8'h00;
      data_rdata_o        <= 8'h00;
      flash_rd_o          <= 1'b0;
      flash_fetch_o       <= 1'b0;
      flash_wr_o          <= 1'b0;
      flash_addr_o        <= '0;
      flash_wdata_o       <= 8'h00;
      flash_bank_o        <= PFBM_BANK0;
      reserved_hit_o      <= 1'b0;
      xdata_rd_o          <= 1'b0;
      xdata_wr_o          <= 1'b0;
      xdata_addr_o        <= '0;
      xdata_wdata_o       <= 8'h00;
    end
    else
    begin
      program_bank_select <= next_program_bank_select;
      exec_bank           <= next_exec_bank;
      data_mem            <= next_data_mem;
      sfr_rdata_o         <= next_sfr_rdata;
      data_rdata_o        <= next_data_rdata;
      flash_rd_o          <= next_flash_rd;
      flash_fetch_o       <= next_flash_fetch;
      flash_wr_o          <= next_flash_wr;
      flash_addr_o        <= next_flash_addr;
      flash_wdata_o       <= next_flash_wdata;
      flash_bank_o        <= next_flash_bank;
      reserved_hit_o      <= next_reserved_hit;
      xdata_rd_o          <= next_xdata_rd;
      xdata_wr_o          <= next_xdata_wr;
      xdata_addr_o        <= next_xdata_addr;
      xdata_wdata_o       <= next_xdata_wdata;
    end
  end

endmodule

// File: pfbm_monitor.sv
`timescale 1ns/1ns
module pfbm_monitor
  import pfbm_pkg::*;
#(
  parameter bit BANKED = 1'b1
)
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  // Core requests
  input wire logic        fetch_req_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic        const_rd_i,
  input wire logic [15:0] const_addr_i,
  input wire logic        xmove_rd_i,
  input wire logic        xmove_wr_i,
  input wire logic [15:0] xmove_addr_i,
  input wire logic [7:0]  xmove_wdata_i,
  input wire logic        program_store_wr_en_i,
  // Flash and external data side
  input wire logic        flash_rd_o,
  input wire logic        flash_fetch_o,
  input wire logic        flash_wr_o,
  input wire logic [16:0] flash_addr_o,
  input wire logic [7:0]  flash_wdata_o,
  input wire logic [1:0]  flash_bank_o,
  input wire logic        reserved_hit_o,
  input wire logic        xdata_rd_o,
  input wire logic        xdata_wr_o,
  input wire logic [15:0] xdata_addr_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Lower priority requests count only when nothing above them is asked
  sequence s_const;
    const_rd_i && !fetch_req_i;
  endsequence
  sequence s_xwr;
    xmove_wr_i && !fetch_req_i && !const_rd_i;
  endsequence
  property p_lo;
    fetch_req_i && !fetch_addr_i[15] |=> flash_rd_o && flash_fetch_o
      && flash_addr_o == {1'b0, $past(fetch_addr_i)};
  endproperty
  property p_lo_const;
    s_const ##0 !const_addr_i[15] |=> flash_rd_o && flash_bank_o == PFBM_BANK0;
  endproperty
  // Flat variant keeps the core address whole, so bit 15 stays set there
  property p_up;
    fetch_req_i && fetch_addr_i[15] |=> reserved_hit_o || (flash_fetch_o
      && flash_addr_o[14:0] == 15'($past(fetch_addr_i))
      && flash_addr_o[16:15] == (BANKED ? flash_bank_o : 2'b01));
  endproperty
  property p_flat;
    fetch_req_i |=> BANKED || (!reserved_hit_o && flash_bank_o == PFBM_BANK0
      && flash_addr_o == {1'b0, $past(fetch_addr_i)});
  endproperty
  property p_const;
    s_const |=> reserved_hit_o || (flash_rd_o && !flash_fetch_o
      && flash_addr_o[14:0] == 15'($past(const_addr_i)));
  endproperty
  property p_xw_off;
    s_xwr ##0 !program_store_wr_en_i |=> xdata_wr_o && !flash_wr_o
      && xdata_addr_o == $past(xmove_addr_i);
  endproperty
  property p_xw_on;
    s_xwr ##0 program_store_wr_en_i |=> !xdata_wr_o
      && (reserved_hit_o || (flash_wr_o && flash_wdata_o == $past(xmove_wdata_i)));
  endproperty
  property p_xrd;
    xmove_rd_i && !xmove_wr_i && !fetch_req_i && !const_rd_i |=> xdata_rd_o && !flash_rd_o;
  endproperty
  property p_rsv;
    flash_rd_o || flash_wr_o |-> flash_addr_o < PFBM_RSVD_BASE;
  endproperty
  a_lo: assert property (p_lo) else $error("lower fetch misrouted");
  a_lo_const: assert property (p_lo_const) else $error("lower read misrouted");
  a_up: assert property (p_up) else $error("upper fetch bank wrong");
  a_const: assert property (p_const) else $error("code read misrouted");
  a_xw_off: assert property (p_xw_off) else $error("write reached flash");
  a_xw_on: assert property (p_xw_on) else $error("flash write lost");
  a_xrd: assert property (p_xrd) else $error("move read misrouted");
  a_rsv: assert property (p_rsv) else $error("reserved area accessed");
  a_flat: assert property (p_flat) else $error("flat map wrong");
endmodule

// File: pfbm_flash_model.sv
`timescale 1ns/1ns
module pfbm_flash_model
(
  // Clock
  input  wire logic        clk_sys_i,
  // Flash write strobe from the mapper
  input  wire logic        flash_wr_i,
  input  wire logic        flash_rd_i,
  input  wire logic [16:0] flash_addr_i,
  input  wire logic [7:0]  flash_wdata_i,
  // Count of bytes programmed
  output int               wr_count_o,
  // Byte returned by the last read strobe
  output logic      [7:0]  rd_data_o
);
  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  // One byte per linear address across all four banks
  logic [7:0] mem [0:131071];
  initial wr_count_o = 0;
  // Only a real write strobe programs a byte
  always @(posedge clk_sys_i)
  begin
    if (flash_wr_i === 1'b1)
    begin
      mem[flash_addr_i] <= flash_wdata_i;
      wr_count_o <= wr_count_o + 1;
    end
    if (flash_rd_i === 1'b1)
      rd_data_o <= mem[flash_addr_i];
  end
endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import pfbm_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, model and checks
  // ----------------------------------------------------------------
  logic clk_sys_i = 0, sys_rst_i = 1, fetch_req_i = 0, const_rd_i = 0, xmove_rd_i = 0;
  logic xmove_wr_i = 0, program_store_wr_en_i = 0, sfr_rd_i = 0, sfr_wr_i = 0;
  logic data_rd_i = 0, data_wr_i = 0;
  logic [15:0] fetch_addr_i = 0, const_addr_i = 0, xmove_addr_i = 0, xdata_addr_o;
  logic [7:0]  xmove_wdata_i = 0, sfr_addr_i = 0, sfr_wdata_i = 0, data_addr_i = 0;
  logic [7:0]  data_wdata_i = 0, sfr_rdata_o, data_rdata_o, flash_wdata_o, xdata_wdata_o;
  logic        flash_rd_o, flash_fetch_o, flash_wr_o, reserved_hit_o, xdata_rd_o, xdata_wr_o;
  logic [16:0] flash_addr_o;
  logic [1:0]  flash_bank_o, xb = 0;
  logic [31:0] rnd = 32'h76c3df07;
  logic [7:0]  sel = 8'h11;
  int          failures = 0, checked = 0, nwr = 0, wr_count;
  logic [16:0] flat_addr;
  logic        flat_rd, flat_rsvd, wok = 0;
  logic [15:0] wa = 0;
  logic [7:0]  wd = 0, rd_data;

  pfbm_mapper #(.BANKED(1'b1)) u_pfbm_mapper (.clk_sys_i, .sys_rst_i, .fetch_req_i,
    .fetch_addr_i, .const_rd_i, .const_addr_i, .xmove_rd_i, .xmove_wr_i, .xmove_addr_i,
    .xmove_wdata_i, .program_store_wr_en_i, .sfr_rd_i, .sfr_wr_i, .sfr_addr_i, .sfr_wdata_i,
    .sfr_rdata_o, .data_rd_i, .data_wr_i, .data_addr_i, .data_wdata_i, .data_rdata_o,
    .flash_rd_o, .flash_fetch_o, .flash_wr_o, .flash_addr_o, .flash_wdata_o, .flash_bank_o,
    .reserved_hit_o, .xdata_rd_o, .xdata_wr_o, .xdata_addr_o, .xdata_wdata_o);
  // Unbanked variant on the same stimulus
  pfbm_mapper #(.BANKED(1'b0)) u_pfbm_mapper_flat (.clk_sys_i, .sys_rst_i, .fetch_req_i,
    .fetch_addr_i, .const_rd_i, .const_addr_i, .xmove_rd_i, .xmove_wr_i, .xmove_addr_i,
    .xmove_wdata_i, .program_store_wr_en_i, .sfr_rd_i, .sfr_wr_i, .sfr_addr_i, .sfr_wdata_i,
    .sfr_rdata_o(), .data_rd_i, .data_wr_i, .data_addr_i, .data_wdata_i, .data_rdata_o(),
    .flash_rd_o(flat_rd), .flash_fetch_o(), .flash_wr_o(), .flash_addr_o(flat_addr),
    .flash_wdata_o(), .flash_bank_o(), .reserved_hit_o(flat_rsvd), .xdata_rd_o(),
    .xdata_wr_o(), .xdata_addr_o(), .xdata_wdata_o());
  pfbm_flash_model u_pfbm_flash_model (.clk_sys_i, .flash_wr_i(flash_wr_o),
    .flash_rd_i(flash_rd_o), .flash_addr_i(flash_addr_o), .flash_wdata_i(flash_wdata_o),
    .wr_count_o(wr_count), .rd_data_o(rd_data));

  initial forever #50 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic test_done;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic sfr(input logic wr, input logic [7:0] a, d);
    sfr_wr_i = wr;
    sfr_rd_i = !wr;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    step;
    if (!wr)
      chk(sfr_rdata_o, (a == PFBM_BANK_SEL_ADDR) ? sel : 8'h00);
    else if (a == PFBM_BANK_SEL_ADDR)
      sel = {2'h0, d[5:4], 2'h0, (xb == PFBM_BANK0) ? d[1:0] : sel[1:0]};
    sfr_wr_i = 0;
    sfr_rd_i = 0;
    step;
  endtask
  // Kinds: 0 fetch, 1 code read, 2 move write, 3 move read; one idle cycle after each
  task automatic acc(input int k, input logic [15:0] a, input logic en);
    logic [1:0]  f;
    logic [7:0]  d;
    logic        rsv;
    f = a[15] ? ((k == 0) ? sel[1:0] : sel[5:4]) : PFBM_BANK0;
    rsv = {f, a[14:0]} >= PFBM_RSVD_BASE;
    d = rnd[7:0];
    rnd = lfsr(rnd);
    {fetch_req_i, const_rd_i, xmove_wr_i, xmove_rd_i} = {k == 0, k == 1, k == 2, k == 3};
    fetch_addr_i = a;
    const_addr_i = a;
    xmove_addr_i = a;
    xmove_wdata_i = d;
    program_store_wr_en_i = en;
    step;
    if (k == 3 || (k == 2 && !en))
    begin
      chk({xdata_rd_o, xdata_wr_o, flash_wr_o, xdata_addr_o}, {k == 3, k == 2, 1'b0, a});
      if (k == 2)
        chk(xdata_wdata_o, d);
    end
    else
    begin
      chk({reserved_hit_o, flash_rd_o, flash_wr_o, flash_fetch_o},
          rsv ? 4'h8 : {1'b0, k != 2, k == 2, k == 0});
      if (!rsv)
        chk({flash_bank_o, flash_addr_o}, {f, f, a[14:0]});
      if (k < 2)
        chk({flat_rsvd, flat_rd, flat_addr}, {2'b01, 1'b0, a});
      if (k == 2 && !rsv)
      begin
        chk(flash_wdata_o, d);
        nwr++;
        wa = a;
        wd = d;
        wok = 1;
      end
      if (k == 0)
        xb = f;
    end
    {fetch_req_i, const_rd_i, xmove_wr_i, xmove_rd_i} = 4'h0;
    step;
  endtask

  initial
  begin
    #1000000;
    failures++;
    test_done;
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 0;
    sfr(0, 8'hb1, 8'h00);
    acc(0, 16'h9000, 0);
    sfr(1, 8'hb1, 8'h22);
    sfr(0, 8'hb1, 8'h00);
    sfr(0, 8'h5a, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      acc(0, {1'b0, rnd[14:0]}, 0);
      sfr(1, 8'hb1, {2'h3, 2'(i), 2'h3, 2'(i)});
      sfr(0, 8'hb1, 8'h00);
      acc(1, {1'b1, rnd[14:0]}, 0);
      wok = 0;
      acc(2, {1'b1, rnd[14:0]}, 1);
      acc(2, rnd[15:0], 0);
      acc(3, rnd[15:0], 1);
      // A code read through the same field must find the byte just programmed
      if (wok)
      begin
        acc(1, wa, 0);
        chk(rd_data, wd);
      end
      acc(1, {1'b0, rnd[14:0]}, 0);
      acc(0, {1'b1, rnd[14:0] & 15'h7bff}, 0);
    end
    acc(1, {6'h3f, rnd[9:0]}, 0);
    acc(2, 16'hffff, 1);
    // Second reset in mid-run: fields back to 01, executing bank back to 0
    sys_rst_i = 1;
    step;
    sys_rst_i = 0;
    sel = PFBM_BANK_SEL_RST;
    xb = PFBM_BANK0;
    sfr(0, 8'hb1, 8'h00);
    sfr(1, 8'hb1, 8'h02);
    acc(0, 16'h8123, 0);
    data_wr_i = 1;
    data_addr_i = rnd[7:0] | 8'h80;
    data_wdata_i = rnd[15:8];
    step;
    data_wr_i = 0;
    data_rd_i = 1;
    step;
    data_rd_i = 0;
    chk(data_rdata_o, rnd[15:8]);
    chk(wr_count, nwr);
    test_done;
  end
endmodule

bind pfbm_mapper pfbm_monitor #(.BANKED(BANKED)) u_pfbm_monitor (.*);
